/* File: rtl/brag_pkg.sv */
// Package of constants for the bit-reversed address generator
// Summary of operation
// - Index added with carries flowing downward
// - Reversal index spans 24 bits, max 00ffffff
// - Reversal offered on processor and DMA paths
// - Separate DMA read and write reversal enables
// - DMA source/destination index sets reversal span
// - Reversed reads work with unified autoinitialization
package brag_pkg;
    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int ADDR_W = 32;
    localparam int INDEX_W = 24;
    localparam logic [INDEX_W-1:0] INDEX_MAX = 24'hffffff;
    localparam logic [ADDR_W-1:0] POINTER_RESET = 32'h00000000;
    localparam logic [INDEX_W-1:0] INDEX_RESET = 24'h000000;
endpackage : brag_pkg

/* File: rtl/brag_rev_add.sv */
// Reverse-carry adder over the low index span of an address
`timescale 1ns/1ns
module brag_rev_add
    import brag_pkg::*;
(
    input wire logic [ADDR_W-1:0] base_i,
    input wire logic [INDEX_W-1:0] index_i,
    output logic [ADDR_W-1:0] sum_o
);
    // ------------------------------------------------------------
    // Carry runs from bit 23 toward bit 0; upper bits pass through
    // ------------------------------------------------------------
    always_comb begin
        logic carry;
        carry = 1'b0;
        sum_o = base_i;
        for (int i = INDEX_W - 1; i >= 0; i--) begin
            sum_o[i] = base_i[i] ^ index_i[i] ^ carry;
            carry = (base_i[i] & index_i[i]) | (carry & (base_i[i] ^ index_i[i]));
        end
    end
endmodule : brag_rev_add

/* File: rtl/brag_top.sv */
// Bit-reversed address generator for processor and DMA paths
`timescale 1ns/1ns
module brag_top
    import brag_pkg::*;
(
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    // Processor pointer path
    input wire logic CPU_LOAD_I,
    input wire logic [ADDR_W-1:0] CPU_LOAD_VALUE_I,
    input wire logic [INDEX_W-1:0] REVERSAL_INDEX_I,
    input wire logic CPU_STEP_I,
    input wire logic CPU_REVERSE_I,
    output logic [ADDR_W-1:0] DATA_POINTER_O,
    output logic CPU_ACCESS_VALID_O,
    output logic [ADDR_W-1:0] CPU_ACCESS_ADDR_O,
    // DMA path
    input wire logic DMA_START_I,
    input wire logic [ADDR_W-1:0] DMA_SRC_ADDR_I,
    input wire logic [ADDR_W-1:0] DMA_DST_ADDR_I,
    input wire logic [INDEX_W-1:0] DMA_SRC_INDEX_I,
    input wire logic [INDEX_W-1:0] DMA_DST_INDEX_I,
    input wire logic DMA_REVERSE_READ_ENABLE_I,
    input wire logic DMA_REVERSE_WRITE_ENABLE_I,
    input wire logic DMA_AUTOINIT_I,
    input wire logic DMA_STEP_I,
    output logic [ADDR_W-1:0] DMA_SRC_ADDR_O,
    output logic [ADDR_W-1:0] DMA_DST_ADDR_O,
    output logic DMA_ACCESS_VALID_O,
    output logic [ADDR_W-1:0] DMA_RD_ADDR_O,
    output logic [ADDR_W-1:0] DMA_WR_ADDR_O
);
    // ------------------------------------------------------------
    // Reverse-carry sums for each pointer
    // ------------------------------------------------------------
    logic [ADDR_W-1:0] cpu_rev_sum;
    logic [ADDR_W-1:0] src_rev_sum;
    logic [ADDR_W-1:0] dst_rev_sum;
    logic [ADDR_W-1:0] next_src;
    logic [ADDR_W-1:0] next_dst;
    logic [ADDR_W-1:0] src_start;
    logic [ADDR_W-1:0] dst_start;
    logic [INDEX_W-1:0] src_index;
    logic [INDEX_W-1:0] dst_index;
    logic rd_rev;
    logic wr_rev;

    function automatic logic [ADDR_W-1:0] lin_add(input logic [ADDR_W-1:0] a,
                                                  input logic [INDEX_W-1:0] b);
        lin_add = a + {{(ADDR_W-INDEX_W){1'b0}}, b};
    endfunction : lin_add

    brag_rev_add u_cpu_add (
        .base_i(DATA_POINTER_O),
        .index_i(REVERSAL_INDEX_I),
        .sum_o(cpu_rev_sum)
    );
    brag_rev_add u_src_add (
        .base_i(DMA_SRC_ADDR_O),
        .index_i(src_index),
        .sum_o(src_rev_sum)
    );
    brag_rev_add u_dst_add (
        .base_i(DMA_DST_ADDR_O),
        .index_i(dst_index),
        .sum_o(dst_rev_sum)
    );

    // ------------------------------------------------------------
    // Processor pointer, post-modify
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            DATA_POINTER_O <= POINTER_RESET;
        end else if (CPU_LOAD_I) begin
            DATA_POINTER_O <= CPU_LOAD_VALUE_I;
        end else if (CPU_STEP_I) begin
            // Access already used the old value; write back the sum
            DATA_POINTER_O <= CPU_REVERSE_I ? cpu_rev_sum :
                lin_add(DATA_POINTER_O, REVERSAL_INDEX_I);
        end
    end

    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            CPU_ACCESS_VALID_O <= 1'b0;
            CPU_ACCESS_ADDR_O <= POINTER_RESET;
        end else begin
            CPU_ACCESS_VALID_O <= CPU_STEP_I & ~CPU_LOAD_I;
            CPU_ACCESS_ADDR_O <= DATA_POINTER_O;
        end
    end

    // ------------------------------------------------------------
    // DMA control word and start values kept for autoinit
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            rd_rev <= 1'b0;
            wr_rev <= 1'b0;
            src_index <= INDEX_RESET;
            dst_index <= INDEX_RESET;
            src_start <= POINTER_RESET;
            dst_start <= POINTER_RESET;
        end else if (DMA_START_I) begin
            rd_rev <= DMA_REVERSE_READ_ENABLE_I;
            wr_rev <= DMA_REVERSE_WRITE_ENABLE_I;
            src_index <= DMA_SRC_INDEX_I;
            dst_index <= DMA_DST_INDEX_I;
            src_start <= DMA_SRC_ADDR_I;
            dst_start <= DMA_DST_ADDR_I;
        end
    end

    // Linear mode steps by the index too, so one index register serves both
    always_comb begin
        next_src = rd_rev ? src_rev_sum : lin_add(DMA_SRC_ADDR_O, src_index);
        next_dst = wr_rev ? dst_rev_sum : lin_add(DMA_DST_ADDR_O, dst_index);
    end

    // ------------------------------------------------------------
    // DMA address sequencing
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            DMA_SRC_ADDR_O <= POINTER_RESET;
            DMA_DST_ADDR_O <= POINTER_RESET;
        end else if (DMA_START_I) begin
            DMA_SRC_ADDR_O <= DMA_SRC_ADDR_I;
            DMA_DST_ADDR_O <= DMA_DST_ADDR_I;
        end else if (DMA_AUTOINIT_I) begin
            // Reload keeps the reversal enables, so reordering repeats
            DMA_SRC_ADDR_O <= src_start;
            DMA_DST_ADDR_O <= dst_start;
        end else if (DMA_STEP_I) begin
            DMA_SRC_ADDR_O <= next_src;
            DMA_DST_ADDR_O <= next_dst;
        end
    end

    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            DMA_ACCESS_VALID_O <= 1'b0;
            DMA_RD_ADDR_O <= POINTER_RESET;
            DMA_WR_ADDR_O <= POINTER_RESET;
        end else begin
            DMA_ACCESS_VALID_O <= DMA_STEP_I & ~DMA_START_I & ~DMA_AUTOINIT_I;
            DMA_RD_ADDR_O <= DMA_SRC_ADDR_O;
            DMA_WR_ADDR_O <= DMA_DST_ADDR_O;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_cpu_rev;
        @(posedge REF_CLK_I) disable iff (RST_I)
        (CPU_STEP_I && CPU_REVERSE_I && !CPU_LOAD_I) |=> DATA_POINTER_O == $past(cpu_rev_sum);
    endproperty
    a_cpu_rev: assert property (p_cpu_rev) else $error("Pointer missed reverse sum");

    property p_rev_top_bit;
        @(posedge REF_CLK_I) disable iff (RST_I)
        (CPU_STEP_I && CPU_REVERSE_I && !CPU_LOAD_I && REVERSAL_INDEX_I == 24'h800000
         && !DATA_POINTER_O[23])
        |=> DATA_POINTER_O[23] && DATA_POINTER_O[22:0] == $past(DATA_POINTER_O[22:0]);
    endproperty
    a_rev_top_bit: assert property (p_rev_top_bit) else $error("Top index bit wrong");

    property p_cpu_post;
        @(posedge REF_CLK_I) disable iff (RST_I)
        (CPU_STEP_I && !CPU_LOAD_I) |=> CPU_ACCESS_VALID_O && CPU_ACCESS_ADDR_O == $past(DATA_POINTER_O);
    endproperty
    a_cpu_post: assert property (p_cpu_post) else $error("Access not at old pointer");

    property p_upper_keep;
        @(posedge REF_CLK_I) disable iff (RST_I)
        (CPU_STEP_I && CPU_REVERSE_I && !CPU_LOAD_I)
        |=> DATA_POINTER_O[31:24] == $past(DATA_POINTER_O[31:24]);
    endproperty
    a_upper_keep: assert property (p_upper_keep) else $error("Upper bits changed");

    property p_src_rev;
        @(posedge REF_CLK_I) disable iff (RST_I)
        (DMA_STEP_I && !DMA_START_I && !DMA_AUTOINIT_I && rd_rev) |=> DMA_SRC_ADDR_O == $past(src_rev_sum);
    endproperty
    a_src_rev: assert property (p_src_rev) else $error("Source not reversed");

    property p_dst_lin;
        @(posedge REF_CLK_I) disable iff (RST_I)
        (DMA_STEP_I && !DMA_START_I && !DMA_AUTOINIT_I && !wr_rev)
        |=> DMA_DST_ADDR_O == $past(DMA_DST_ADDR_O) + {8'h00, $past(dst_index)};
    endproperty
    a_dst_lin: assert property (p_dst_lin) else $error("Destination not linear");

    property p_enable_load;
        @(posedge REF_CLK_I) disable iff (RST_I)
        DMA_START_I |=> rd_rev == $past(DMA_REVERSE_READ_ENABLE_I) && wr_rev == $past(DMA_REVERSE_WRITE_ENABLE_I);
    endproperty
    a_enable_load: assert property (p_enable_load) else $error("Enables not captured");

    property p_autoinit;
        @(posedge REF_CLK_I) disable iff (RST_I)
        (DMA_AUTOINIT_I && !DMA_START_I) |=> DMA_SRC_ADDR_O == src_start && $stable(rd_rev);
    endproperty
    a_autoinit: assert property (p_autoinit) else $error("Autoinit lost reversal");
endmodule : brag_top

/* File: verification/bit_reversed_address_gen_tb.sv */
// Self-checking bench for the bit-reversed address generator
`timescale 1ns/1ns
module bit_reversed_address_gen_tb;
    import brag_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ld = 1'b0, stp = 1'b0, rv = 1'b0, ds = 1'b0, ren = 1'b0, wen = 1'b0;
    logic ai = 1'b0, dst = 1'b0, cv, dv;
    logic [ADDR_W-1:0] lv = '0, sa = '0, da = '0, ptr, cad, so, dov, rda, wra, ep, es, ed;
    logic [INDEX_W-1:0] ix = '0, si = '0, di = '0;
    int miscompares = 0;
    int n_compared = 0;
    int seed = 46;
    initial forever #10 clk = ~clk;
    brag_top dut_u (.REF_CLK_I(clk), .RST_I(rst), .CPU_LOAD_I(ld), .CPU_LOAD_VALUE_I(lv),
        .REVERSAL_INDEX_I(ix), .CPU_STEP_I(stp), .CPU_REVERSE_I(rv), .DATA_POINTER_O(ptr),
        .CPU_ACCESS_VALID_O(cv), .CPU_ACCESS_ADDR_O(cad), .DMA_START_I(ds),
        .DMA_SRC_ADDR_I(sa), .DMA_DST_ADDR_I(da), .DMA_SRC_INDEX_I(si), .DMA_DST_INDEX_I(di),
        .DMA_REVERSE_READ_ENABLE_I(ren), .DMA_REVERSE_WRITE_ENABLE_I(wen),
        .DMA_AUTOINIT_I(ai), .DMA_STEP_I(dst), .DMA_SRC_ADDR_O(so), .DMA_DST_ADDR_O(dov),
        .DMA_ACCESS_VALID_O(dv), .DMA_RD_ADDR_O(rda), .DMA_WR_ADDR_O(wra));
    brag_mem_model mem_u (.clk_i(clk), .valid_i(dv), .rd_addr_i(rda), .wr_addr_i(wra));
    // ------------------------------------------------------------
    // Expectation and reporting
    // ------------------------------------------------------------
    function automatic logic [ADDR_W-1:0] radd(input logic [ADDR_W-1:0] b,
                                               input logic [INDEX_W-1:0] i, input logic r);
        logic [INDEX_W-1:0] rb, ri, s;
        if (!r) return b + {8'h00, i};
        for (int k = 0; k < INDEX_W; k++) begin
            rb[k] = b[INDEX_W-1-k];
            ri[k] = i[INDEX_W-1-k];
        end
        s = rb + ri;
        for (int k = 0; k < INDEX_W; k++) rb[k] = s[INDEX_W-1-k];
        return {b[ADDR_W-1:INDEX_W], rb};
    endfunction : radd
    task automatic check(input string what, input logic [ADDR_W-1:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic final_report;
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : final_report
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        #100000;
        miscompares++;
        final_report();
    end
    initial begin
        repeat (3) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        check("pointer", ptr, '0);
        // Interleaved table: base with n+1 low bits clear, index N
        ld = 1'b1;
        lv = 32'h00001000;
        ep = lv;
        // Load alone for one cycle so the first step starts from the table base
        @(negedge clk);
        check("pointer", ptr, ep);
        // Back-to-back steps; one load collides with a step
        for (int k = 0; k < 40; k++) begin
            ix = (k < 3) ? INDEX_MAX : (k == 18) ? 24'h800000 :
                (k < 20) ? 24'h000200 : INDEX_W'($random(seed));
            rv = (k % 3 != 2);
            stp = 1'b1;
            ld = (k == 5);
            @(negedge clk);
            check("cpu valid", cv, k != 5);
            if (k == 5) ep = lv;
            else begin
                check("cpu addr", cad, ep);
                ep = radd(ep, ix, rv);
            end
            check("pointer", ptr, ep);
        end
        stp = 1'b0;
        $display("cpu test done");
        // Four blocks cover every read/write reversal mode; split tables use N/2
        for (int b = 0; b < 4; b++) begin
            ds = 1'b1;
            {ren, wen} = 2'(b);
            sa = (b == 0) ? 32'h00000400 : (b == 1) ? 32'h00000600 : $random(seed);
            da = 32'h00000800 + b;
            si = (b < 2) ? 24'h000100 : INDEX_W'($random(seed));
            di = (b == 3) ? INDEX_MAX : 24'h000002;
            @(negedge clk) ds = 1'b0;
            es = sa;
            ed = da;
            for (int k = 0; k < 12; k++) begin
                dst = 1'b1;
                ai = (k == 8);
                @(negedge clk);
                check("dma valid", dv, k != 8);
                if (k == 8) begin
                    es = sa;
                    ed = da;
                end else begin
                    check("dma rd", rda, es);
                    check("dma wr", wra, ed);
                    es = radd(es, si, ren);
                    ed = radd(ed, di, wen);
                end
                check("dma src", so, es);
                check("dma dst", dov, ed);
            end
            dst = 1'b0;
            ai = 1'b0;
            $display("dma block %0d done", b);
        end
        final_report();
    end
endmodule : bit_reversed_address_gen_tb

/* File: verification/brag_mem_model.sv */
// Behavioural data memory at the far side of the DMA path
`timescale 1ns/1ns
module brag_mem_model
    import brag_pkg::*;
(
    input wire logic clk_i,
    input wire logic valid_i,
    input wire logic [ADDR_W-1:0] rd_addr_i,
    input wire logic [ADDR_W-1:0] wr_addr_i
);
    logic [ADDR_W-1:0] mem [0:255];
    // Small window only; upper address bits alias
    always @(posedge clk_i) begin
        if (valid_i) begin
            mem[wr_addr_i[7:0]] <= mem[rd_addr_i[7:0]];
        end
    end
endmodule : brag_mem_model
